// File: common/oug_pkg.sv
// Notes on behaviour
// - Decode an 8-bit address space of 256 byte locations.
// - Addresses 0x00-0x7F select channel n in window n*16 to n*16+15.
// - Global registers sit at 0x80-0x8F; unused and 0x85, 0x89 read zero.
// - Global registers are reached by one direct bus access, no index step.
// - Summary register bit n is one while channel n requests service; bit 0 is also one while the timer interrupt is pending.
// - Three locator registers pack 3-bit source codes, channel 0 lowest, straddling.
// - Timer control: bit0 irq enable, bit1 start, bit2 function, bit3 clock; upper zero.
// - Timer value low byte and high byte are read/write at consecutive addresses.
// - Oversample bit n one selects 8x for channel n, zero selects 16x.
// - Writing one to channel reset bit n resets channel n; zero does nothing.
// - Sleep register holds one read/write sleep-enable bit per channel.
// - Revision and identification registers are fixed read-only; writes ignored.
// - Broadcast bit0 set makes a channel write hit all eight channels.
// - Sleep is allowed only when every sleep bit is one.
// - Timer time-out code appears only for channel 0; reserved elsewhere.
// - Reading timer control clears a pending timer interrupt.
package oug_pkg;
    localparam logic [7:0] OFS_SUMMARY = 8'h80;
    localparam logic [7:0] OFS_LOC_LOW = 8'h81;
    localparam logic [7:0] OFS_LOC_MID = 8'h82;
    localparam logic [7:0] OFS_LOC_HIGH = 8'h83;
    localparam logic [7:0] OFS_TMR_CTRL = 8'h84;
    localparam logic [7:0] OFS_ZERO_A = 8'h85;
    localparam logic [7:0] OFS_TMR_LOW = 8'h86;
    localparam logic [7:0] OFS_TMR_HIGH = 8'h87;
    localparam logic [7:0] OFS_OVERSAMPLE = 8'h88;
    localparam logic [7:0] OFS_ZERO_B = 8'h89;
    localparam logic [7:0] OFS_CHAN_CLEAR = 8'h8A;
    localparam logic [7:0] OFS_LOW_POWER = 8'h8B;
    localparam logic [7:0] OFS_REVISION = 8'h8C;
    localparam logic [7:0] OFS_DEVICE_ID = 8'h8D;
    localparam logic [7:0] OFS_BROADCAST = 8'h8E;
    localparam logic [3:0] GLOBAL_WINDOW = 4'h8;
    localparam int TC_IRQ_EN_BIT = 0;
    localparam int TC_START_BIT = 1;
    localparam int TC_FUNC_BIT = 2;
    localparam int TC_CLKSRC_BIT = 3;
    localparam int BCAST_BIT = 0;
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_TIMER = 3'h7;
    localparam logic [3:0] RST_TMR_CTRL = 4'h0;
    localparam logic [15:0] RST_TMR_VALUE = 16'h0000;
    localparam logic [7:0] RST_OVERSAMPLE = 8'h00;
    localparam logic [7:0] RST_LOW_POWER = 8'h00;
    localparam logic [7:0] RST_BROADCAST = 8'h00;
    localparam logic [7:0] ALL_CHANNELS = 8'hFF;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic csB;
        logic rdB;
        logic wrB;
    } oug_host_t;

    typedef struct packed {
        logic [7:0] sel;
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } oug_chan_t;
endpackage : oug_pkg

// File: hdl/oug_global_regs.sv
`timescale 1ns/10ps
module oug_global_regs #(
    parameter logic [7:0] REVISION_VALUE = 8'h01, // Arbitrary value
    parameter logic [7:0] DEVICE_ID_VALUE = 8'h5A // Arbitrary value
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Host bus pins
    input wire oug_pkg::oug_host_t hostPins,
    output logic [7:0] dataOut_q,
    output logic dataOeB_q,
    // Channel side
    input wire logic [7:0] chanIrq,
    input wire logic [7:0][2:0] chanSrc,
    input wire logic [7:0] chanRdata,
    output oug_pkg::oug_chan_t chanAcc_q,
    output logic [7:0] chanReset_q,
    // Global controls
    input wire logic timerTimeout,
    output logic [3:0] timerCtrl_q,
    output logic [15:0] timerValue_q,
    output logic [7:0] oversample_q,
    output logic [7:0] sleepEn_q,
    output logic sleepAllowed_q,
    output logic timerIrq_q
);
    import oug_pkg::*;

    logic [1:0] rstSync_q;
    logic rstN;
    oug_host_t hostS1_q;
    oug_host_t hostS2_q;
    logic rdPrev_q;
    logic wrPrev_q;
    logic [7:0] bcast_q;
    logic rdActive;
    logic wrActive;
    logic rdEdge;
    logic wrEdge;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic isGlobal;
    logic [23:0] srcVec;
    logic [7:0] summary;
    logic [7:0] readVal;
    logic timerClear;
    logic timerSet;

    // Reset released through two flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    // Pins pass two flops; address and data are stable while a strobe is low
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            hostS1_q <= '{addr: 8'h00, wdata: 8'h00, csB: 1'b1, rdB: 1'b1, wrB: 1'b1};
            hostS2_q <= '{addr: 8'h00, wdata: 8'h00, csB: 1'b1, rdB: 1'b1, wrB: 1'b1};
        end else begin
            hostS1_q <= hostPins;
            hostS2_q <= hostS1_q;
        end
    end

    assign addr = hostS2_q.addr;
    assign wdata = hostS2_q.wdata;
    assign rdActive = !hostS2_q.csB && !hostS2_q.rdB;
    assign wrActive = !hostS2_q.csB && !hostS2_q.wrB;
    assign rdEdge = rdActive && !rdPrev_q;
    assign wrEdge = wrActive && !wrPrev_q;
    assign isGlobal = (addr[7:4] == GLOBAL_WINDOW);

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            rdPrev_q <= 1'b0;
            wrPrev_q <= 1'b0;
        end else begin
            rdPrev_q <= rdActive;
            wrPrev_q <= wrActive;
        end
    end

    // Source codes; timer shows only on channel 0, lowest priority there
    always_comb begin
        srcVec = 24'h000000;
        for (int i = 0; i < 8; i++) begin
            srcVec[i*3 +: 3] = (chanSrc[i] == SRC_TIMER) ? SRC_NONE : chanSrc[i];
        end
        if (srcVec[2:0] == SRC_NONE && timerIrq_q) begin
            srcVec[2:0] = SRC_TIMER;
        end
    end

    assign summary = {chanIrq[7:1], chanIrq[0] | timerIrq_q};

    // Read mux
    always_comb begin
        readVal = 8'h00;
        if (!isGlobal) begin
            readVal = chanRdata;
        end else begin
            unique case (addr)
                OFS_SUMMARY: readVal = summary;
                OFS_LOC_LOW: readVal = srcVec[7:0];
                OFS_LOC_MID: readVal = srcVec[15:8];
                OFS_LOC_HIGH: readVal = srcVec[23:16];
                OFS_TMR_CTRL: readVal = {4'h0, timerCtrl_q};
                OFS_TMR_LOW: readVal = timerValue_q[7:0];
                OFS_TMR_HIGH: readVal = timerValue_q[15:8];
                OFS_OVERSAMPLE: readVal = oversample_q;
                OFS_LOW_POWER: readVal = sleepEn_q;
                OFS_REVISION: readVal = REVISION_VALUE;
                OFS_DEVICE_ID: readVal = DEVICE_ID_VALUE;
                OFS_BROADCAST: readVal = bcast_q;
                default: readVal = 8'h00;
            endcase
        end
    end

    // Data bus drive, low enable while reading
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            dataOut_q <= 8'h00;
            dataOeB_q <= 1'b1;
        end else begin
            dataOeB_q <= !rdActive;
            if (rdActive) begin
                dataOut_q <= readVal;
            end
        end
    end

    // Channel access strobes; broadcast widens a write to all channels
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            chanAcc_q <= '{sel: 8'h00, addr: 4'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        end else begin
            chanAcc_q.wr <= wrEdge && !isGlobal;
            chanAcc_q.rd <= rdEdge && !isGlobal;
            chanAcc_q.addr <= addr[3:0];
            chanAcc_q.wdata <= wdata;
            if ((wrEdge || rdEdge) && !isGlobal) begin
                if (wrEdge && bcast_q[BCAST_BIT]) begin
                    chanAcc_q.sel <= ALL_CHANNELS;
                end else begin
                    chanAcc_q.sel <= 8'h01 << addr[6:4];
                end
            end else begin
                chanAcc_q.sel <= 8'h00;
            end
        end
    end

    // Global register writes
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            timerCtrl_q <= RST_TMR_CTRL;
            timerValue_q <= RST_TMR_VALUE;
            oversample_q <= RST_OVERSAMPLE;
            sleepEn_q <= RST_LOW_POWER;
            bcast_q <= RST_BROADCAST;
        end else if (wrEdge && isGlobal) begin
            unique case (addr)
                OFS_TMR_CTRL: timerCtrl_q <= wdata[3:0];
                OFS_TMR_LOW: timerValue_q[7:0] <= wdata;
                OFS_TMR_HIGH: timerValue_q[15:8] <= wdata;
                OFS_OVERSAMPLE: oversample_q <= wdata;
                OFS_LOW_POWER: sleepEn_q <= wdata;
                OFS_BROADCAST: bcast_q <= {7'h00, wdata[BCAST_BIT]};
                default: ;
            endcase
        end
    end

    // One-shot channel resets, only ones act
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            chanReset_q <= 8'h00;
        end else if (wrEdge && addr == OFS_CHAN_CLEAR) begin
            chanReset_q <= wdata;
        end else begin
            chanReset_q <= 8'h00;
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            sleepAllowed_q <= 1'b0;
        end else begin
            sleepAllowed_q <= (sleepEn_q == ALL_CHANNELS);
        end
    end

    // Timer interrupt: a time-out in the clearing cycle is kept
    assign timerSet = timerTimeout && timerCtrl_q[TC_IRQ_EN_BIT];
    assign timerClear = rdEdge && addr == OFS_TMR_CTRL;
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            timerIrq_q <= 1'b0;
        end else if (timerSet) begin
            timerIrq_q <= 1'b1;
        end else if (timerClear) begin
            timerIrq_q <= 1'b0;
        end
    end

    a_tmr_irq_set: assert property (@(posedge clock) disable iff (!rstN)
        timerSet |=> timerIrq_q) else $error("timer interrupt not set");
    a_tmr_rd_clear: assert property (@(posedge clock) disable iff (!rstN)
        timerClear && !timerSet |=> !timerIrq_q) else $error("timer interrupt not cleared by read");
    a_reset_pulse_once: assert property (@(posedge clock) disable iff (!rstN)
        (chanReset_q != 8'h00) && !wrEdge |=> chanReset_q == 8'h00) else $error("channel reset held");
    a_reset_from_write: assert property (@(posedge clock) disable iff (!rstN)
        wrEdge && addr == OFS_CHAN_CLEAR |=> chanReset_q == $past(wdata)) else $error("channel reset mismatch");
    a_sleep_all_ones: assert property (@(posedge clock) disable iff (!rstN)
        wrEdge && addr == OFS_LOW_POWER |=> ##1 sleepAllowed_q == ($past(wdata, 2) == 8'hFF))
        else $error("sleep permission wrong");
    a_bcast_write_all: assert property (@(posedge clock) disable iff (!rstN)
        wrEdge && !isGlobal && bcast_q[0] |=> chanAcc_q.wr && chanAcc_q.sel == 8'hFF)
        else $error("broadcast write not to all channels");
    a_chan_window_sel: assert property (@(posedge clock) disable iff (!rstN)
        wrEdge && !isGlobal && !bcast_q[0] |=> chanAcc_q.sel == (8'h01 << $past(addr[6:4])))
        else $error("channel window select wrong");
    a_zero_reads: assert property (@(posedge clock) disable iff (!rstN)
        rdActive && (addr == OFS_ZERO_A || addr == OFS_ZERO_B || addr == 8'h8F) |=> dataOut_q == 8'h00 && !dataOeB_q)
        else $error("reserved location not zero");
    a_oversample_wr: assert property (@(posedge clock) disable iff (!rstN)
        wrEdge && addr == OFS_OVERSAMPLE |=> oversample_q == $past(wdata)) else $error("oversample not written");
    a_summary_read: assert property (@(posedge clock) disable iff (!rstN)
        rdActive && addr == OFS_SUMMARY |=> dataOut_q == $past(summary) && dataOut_q[7:1] == $past(chanIrq[7:1]))
        else $error("summary read wrong");
    a_src_reserved: assert property (@(posedge clock) disable iff (!rstN)
        chanSrc[7] == 3'h7 |-> srcVec[23:21] == 3'h0) else $error("reserved code shown");
    a_id_fixed: assert property (@(posedge clock) disable iff (!rstN)
        rdActive && addr == OFS_DEVICE_ID |=> dataOut_q == DEVICE_ID_VALUE) else $error("id not fixed");
    a_chan_wr_pulse: assert property (@(posedge clock) disable iff (!rstN)
        chanAcc_q.wr |=> !chanAcc_q.wr)
        else $error("channel write strobe held");
    a_chan_rd_pulse: assert property (@(posedge clock) disable iff (!rstN)
        chanAcc_q.rd |=> !chanAcc_q.rd)
        else $error("channel read strobe held");
    a_global_no_chan: assert property (@(posedge clock) disable iff (!rstN)
        (wrEdge || rdEdge) && isGlobal |=> !chanAcc_q.wr && !chanAcc_q.rd && chanAcc_q.sel == 8'h00)
        else $error("global access reached a channel");
    a_chan_rd_data: assert property (@(posedge clock) disable iff (!rstN)
        rdActive && !isGlobal |=> dataOut_q == $past(chanRdata))
        else $error("channel read data wrong");
    a_chan_rd_sel: assert property (@(posedge clock) disable iff (!rstN)
        rdEdge && !isGlobal |=> chanAcc_q.rd && chanAcc_q.sel == (8'h01 << $past(addr[6:4])))
        else $error("channel read select wrong");
    a_rev_fixed: assert property (@(posedge clock) disable iff (!rstN)
        rdActive && addr == OFS_REVISION |=> dataOut_q == REVISION_VALUE)
        else $error("revision not fixed");
    a_ro_write_ignored: assert property (@(posedge clock) disable iff (!rstN)
        wrEdge && (addr == OFS_REVISION || addr == OFS_DEVICE_ID || addr == OFS_ZERO_A) |=> $stable(timerCtrl_q)
        && $stable(timerValue_q) && $stable(oversample_q) && $stable(sleepEn_q) && $stable(bcast_q))
        else $error("write to read-only location changed state");
    a_src_pack_mid: assert property (@(posedge clock) disable iff (!rstN)
        chanSrc[2] != SRC_TIMER |-> srcVec[8:6] == chanSrc[2])
        else $error("channel 2 code misplaced");
    a_src_straddle: assert property (@(posedge clock) disable iff (!rstN)
        chanSrc[5] != SRC_TIMER |-> srcVec[17:15] == chanSrc[5])
        else $error("channel 5 code misplaced");
    a_timer_src_ch0: assert property (@(posedge clock) disable iff (!rstN)
        timerIrq_q && chanSrc[0] == SRC_NONE |-> srcVec[2:0] == SRC_TIMER)
        else $error("timer code missing on channel 0");
    a_ctrl_wr: assert property (@(posedge clock) disable iff (!rstN)
        wrEdge && addr == OFS_TMR_CTRL |=> timerCtrl_q == $past(wdata[3:0]))
        else $error("timer control not written");
    a_ctrl_upper_zero: assert property (@(posedge clock) disable iff (!rstN)
        rdActive && addr == OFS_TMR_CTRL |=> dataOut_q[7:4] == 4'h0)
        else $error("timer control upper bits not zero");
    a_tmr_low_wr: assert property (@(posedge clock) disable iff (!rstN)
        wrEdge && addr == OFS_TMR_LOW |=> timerValue_q[7:0] == $past(wdata) && $stable(timerValue_q[15:8]))
        else $error("timer low byte write wrong");
    a_tmr_high_wr: assert property (@(posedge clock) disable iff (!rstN)
        wrEdge && addr == OFS_TMR_HIGH |=> timerValue_q[15:8] == $past(wdata) && $stable(timerValue_q[7:0]))
        else $error("timer high byte write wrong");
    a_sleep_wr: assert property (@(posedge clock) disable iff (!rstN)
        wrEdge && addr == OFS_LOW_POWER |=> sleepEn_q == $past(wdata))
        else $error("sleep enables not written");
    a_sleep_partial: assert property (@(posedge clock) disable iff (!rstN)
        sleepEn_q != ALL_CHANNELS |=> !sleepAllowed_q)
        else $error("sleep allowed with a channel disabled");
    a_tmr_irq_hold: assert property (@(posedge clock) disable iff (!rstN)
        timerIrq_q && !timerClear |=> timerIrq_q)
        else $error("timer interrupt lost without a read");
    a_oe_idle: assert property (@(posedge clock) disable iff (!rstN)
        !rdActive |=> dataOeB_q)
        else $error("data bus driven outside a read");
    a_oe_read: assert property (@(posedge clock) disable iff (!rstN)
        rdActive |=> !dataOeB_q)
        else $error("data bus not driven during a read");
    a_bcast_reg_wr: assert property (@(posedge clock) disable iff (!rstN)
        wrEdge && addr == OFS_BROADCAST |=> bcast_q == {7'h00, $past(wdata[BCAST_BIT])})
        else $error("broadcast control not written");
endmodule : oug_global_regs

// File: bench/oug_host_model.sv
`timescale 1ns/10ps
module oug_host_model (
    // Bus clock
    input wire logic clock,
    // Host pins and read data
    output oug_pkg::oug_host_t hostPins,
    input wire logic [7:0] dataOut_q,
    input wire logic dataOeB_q
);
    import oug_pkg::*;
    initial hostPins = '{8'h00, 8'h00, 1'b1, 1'b1, 1'b1};
    // One direct access; address settles 2 cycles early for the pin synchronisers
    task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
        output logic oeB);
        @(negedge clock);
        hostPins.addr = a;
        hostPins.wdata = rd ? ~d : d;
        repeat (2) @(negedge clock);
        hostPins.csB = 1'b0;
        hostPins.rdB = !rd;
        hostPins.wrB = rd;
        repeat (4) @(negedge clock);
        q = dataOut_q;
        oeB = dataOeB_q;
        hostPins.csB = 1'b1;
        hostPins.rdB = 1'b1;
        hostPins.wrB = 1'b1;
        // Released lines scramble so a stale value never looks valid
        repeat (3) @(negedge clock);
        hostPins.addr = ~a;
        hostPins.wdata = ~hostPins.wdata;
    endtask : acc
endmodule : oug_host_model

// File: bench/tb_oug_global_regs.sv
`timescale 1ns/10ps
module tb_oug_global_regs;
    import oug_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    oug_host_t hostPins;
    oug_chan_t chanAcc_q, accSeen;
    logic [7:0] dataOut_q, chanReset_q, oversample_q, sleepEn_q, q, a, d;
    logic [7:0] chanIrq = 8'h00;
    logic [7:0] chanRdata = 8'h00;
    logic [7:0] rstOr = 8'h00;
    logic [7:0][2:0] chanSrc = '0;
    logic dataOeB_q, sleepAllowed_q, timerIrq_q, oe;
    logic timerTimeout = 1'b0;
    logic [3:0] timerCtrl_q;
    logic [15:0] timerValue_q;
    logic [23:0] e;
    logic [31:0] seed = 32'h4E76B3FA;
    logic [7:0] zeroA[10] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8E, 8'h8F};
    logic [7:0] rwA[6] = '{8'h84, 8'h86, 8'h87, 8'h88, 8'h8B, 8'h8E};
    logic [7:0] rwM[6] = '{8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01};
    logic [7:0] m[$];
    int fail_count = 0;
    int cmp_count = 0;
    int rstCnt = 0;
    always #50 clock = ~clock;
    oug_global_regs i_oug_global_regs (.clock(clock), .rst_b(rst_b), .hostPins(hostPins), .dataOut_q(dataOut_q),
        .dataOeB_q(dataOeB_q), .chanIrq(chanIrq), .chanSrc(chanSrc), .chanRdata(chanRdata), .chanAcc_q(chanAcc_q),
        .chanReset_q(chanReset_q), .timerTimeout(timerTimeout), .timerCtrl_q(timerCtrl_q),
        .timerValue_q(timerValue_q), .oversample_q(oversample_q), .sleepEn_q(sleepEn_q),
        .sleepAllowed_q(sleepAllowed_q), .timerIrq_q(timerIrq_q));
    oug_host_model i_oug_host_model (.clock(clock), .hostPins(hostPins), .dataOut_q(dataOut_q),
        .dataOeB_q(dataOeB_q));
    always @(posedge clock) begin
        rstOr <= rstOr | chanReset_q;
        if (chanReset_q !== 8'h00) rstCnt++;
        if (chanAcc_q.wr | chanAcc_q.rd) accSeen <= chanAcc_q;
    end
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd
    task automatic chk(input string n, input logic [23:0] x, input logic [23:0] g);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", n, x, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [7:0] dd);
        i_oug_host_model.acc(1'b0, ad, dd, q, oe);
        chk("writeEnable", 1, oe);
    endtask : wr
    task automatic rdc(input logic [7:0] ad, input logic [7:0] x);
        i_oug_host_model.acc(1'b1, ad, 8'h00, q, oe);
        chk("readData", x, q);
        chk("readEnable", 0, oe);
        chk("idleEnable", 1, dataOeB_q);
    endtask : rdc
    task automatic pulseTimeout();
        @(negedge clock);
        timerTimeout = 1'b1;
        @(negedge clock);
        timerTimeout = 1'b0;
        @(negedge clock);
    endtask : pulseTimeout
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        repeat (5) @(negedge clock);
        foreach (zeroA[i]) rdc(zeroA[i], 8'h00);
        rdc(8'h8C, 8'h01);
        rdc(8'h8D, 8'h5A);
        foreach (rwA[i]) begin
            d = rnd();
            if (rwA[i] == 8'h8E) d = d & 8'h01;
            wr(rwA[i], d);
            m.push_back(d & rwM[i]);
        end
        wr(8'h8C, 8'hFF);
        wr(8'h85, 8'hFF);
        foreach (rwA[i]) rdc(rwA[i], m[i]);
        rdc(8'h8C, 8'h01);
        rdc(8'h85, 8'h00);
        chk("timerCtrl", m[0], timerCtrl_q);
        chk("timerValue", {m[2], m[1]}, timerValue_q);
        chk("oversample", m[3], oversample_q);
        chk("sleepEn", m[4], sleepEn_q);
        wr(8'h8B, 8'hFF);
        chk("sleepAllowed", 1, sleepAllowed_q);
        wr(8'h8B, 8'h7F);
        chk("sleepAllowed", 0, sleepAllowed_q);
        wr(8'h8A, 8'h05);
        chk("chanReset", 8'h05, rstOr);
        chk("resetPulses", 1, rstCnt);
        wr(8'h8E, 8'h00);
        for (int c = 0; c < 8; c++) begin
            a = 8'(c * 16) | (rnd() & 8'h0F);
            d = rnd();
            wr(a, d);
            chk("chanWrite", {1'b1, 8'(1 << c), a[3:0], d},
                {accSeen.wr, accSeen.sel, accSeen.addr, accSeen.wdata});
            chanRdata = rnd();
            rdc(a, chanRdata);
            chk("chanReadSel", {1'b1, 8'(1 << c)}, {accSeen.rd, accSeen.sel});
        end
        wr(8'h8E, 8'h01);
        wr(8'h35, 8'hA5);
        chk("broadcastSel", {1'b1, 8'hFF}, {accSeen.wr, accSeen.sel});
        for (int k = 0; k < 4; k++) begin
            chanIrq = rnd();
            for (int c = 0; c < 8; c++) begin
                chanSrc[c] = 3'(rnd());
                e[c*3 +: 3] = (chanSrc[c] == SRC_TIMER) ? SRC_NONE : chanSrc[c];
            end
            rdc(8'h80, chanIrq);
            rdc(8'h81, e[7:0]);
            rdc(8'h82, e[15:8]);
            rdc(8'h83, e[23:16]);
        end
        chanIrq = 8'h00;
        chanSrc = '0;
        wr(8'h84, 8'h00);
        pulseTimeout();
        chk("timerIrqMasked", 0, timerIrq_q);
        wr(8'h84, 8'h01);
        pulseTimeout();
        chk("timerIrq", 1, timerIrq_q);
        rdc(8'h80, 8'h01);
        rdc(8'h81, 8'h07);
        rdc(8'h84, 8'h01);
        chk("timerIrqCleared", 0, timerIrq_q);
        rdc(8'h80, 8'h00);
        stop_test();
    end
    // Whole run needs about 730 cycles; the margin covers a stuck strobe
    initial begin
        #(5000 * 100);
        fail_count++;
        stop_test();
    end
endmodule : tb_oug_global_regs
